// ---- eip_edge_det.sv ----
// edge detector of selectable polarity for the external interrupt pin
// assumes the pin is synchronous to clk_sys_i
`timescale 1ns/10ps
module eip_edge_det (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic en_i,
   input wire logic pol_i,
   input wire logic pin_i,
   output logic edge_o
);

   // ************************************************************
   // edge detection
   // ************************************************************
   logic prev_r;
   logic edge_r;
   wire logic fall_w = prev_r & ~pin_i;
   wire logic rise_w = ~prev_r & pin_i;
   wire logic hit_w = en_i & (pol_i ? rise_w : fall_w);

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prev_r <= 1'h0;
         edge_r <= 1'h0;
      end else if (ce_i) begin
         prev_r <= pin_i;
         edge_r <= hit_w;
      end
   end

   assign edge_o = edge_r;

   // ************************************************************
   // checks
   // ************************************************************
   property p_fall_seen;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      ce_i && en_i && !pol_i && prev_r && !pin_i |=> edge_o;
   endproperty
   a_fall_seen: assert property (p_fall_seen) else $error("falling edge missed");

   property p_rise_seen;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      ce_i && en_i && pol_i && !prev_r && pin_i |=> edge_o;
   endproperty
   a_rise_seen: assert property (p_rise_seen) else $error("rising edge missed");

   property p_wrong_edge;
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      ce_i && (pol_i ? (prev_r || !pin_i) : (!prev_r || pin_i)) |=> !edge_o;
   endproperty
   a_wrong_edge: assert property (p_wrong_edge) else $error("edge of wrong polarity");

endmodule : eip_edge_det

// ---- eip_edge_irq_pin_unit.sv ----
// top of the external edge interrupt pin unit: registers, pending flag, interrupt outputs
// assumes a single clock, pin level synchronous to it, and a master that never waits
`timescale 1ns/10ps

// Behaviour
// - function bit 1 selects interrupt input
// - polarity 0 detects falling edges
// - polarity 1 detects rising edges
// - enable bit gates request to processor
// - selected edge in interrupt mode sets pending
// - writing 0 clears a set pending flag; the code keeps it set if a selected edge arrives in the same cycle
// - writing 1 to pending has no effect
module eip_edge_irq_pin_unit (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire eip_pkg::eip_bus_req_s bus_req_i,
   output logic [7:0] rdata_o,
   input wire logic shared_port_pin_i,
   output logic pin_is_irq_o,
   output logic irq_req_o,
   output logic evt_irq_o
);

   // ************************************************************
   // register state
   // ************************************************************
   logic pin_function_sel_r;
   logic edge_polarity_sel_r;
   logic irq_pin_enable_r;
   logic irq_pending_flag_r;
   logic [eip_pkg::EVT_W-1:0] evt_status_r;
   logic [eip_pkg::EVT_W-1:0] evt_mask_r;
   logic [7:0] rdata_r;
   logic irq_req_r;
   logic evt_irq_r;
   logic edge_w;

   // ************************************************************
   // address decode
   // ************************************************************
   wire logic wr_w = ce_i & bus_req_i.wr;
   wire logic rd_w = ce_i & bus_req_i.rd;
   wire logic hit_func_w = bus_req_i.addr == eip_pkg::ADDR_PIN_FUNC_SEL;
   wire logic hit_pol_w = bus_req_i.addr == eip_pkg::ADDR_EDGE_POL_CTL;
   wire logic hit_en_w = bus_req_i.addr == eip_pkg::ADDR_IRQ_EN_CTL;
   wire logic hit_pend_w = bus_req_i.addr == eip_pkg::ADDR_IRQ_PEND_STS;
   wire logic hit_stat_w = bus_req_i.addr == eip_pkg::ADDR_EVT_STATUS;
   wire logic hit_mask_w = bus_req_i.addr == eip_pkg::ADDR_EVT_MASK;
   wire logic hit_port_w = bus_req_i.addr == eip_pkg::ADDR_PORT_LEVEL;
   wire logic wr_func_w = wr_w & hit_func_w;
   wire logic wr_pol_w = wr_w & hit_pol_w;
   wire logic wr_en_w = wr_w & hit_en_w;
   wire logic wr_pend_w = wr_w & hit_pend_w;
   wire logic wr_mask_w = wr_w & hit_mask_w;
   wire logic rd_stat_w = rd_w & hit_stat_w;
   wire logic wbit_w = bus_req_i.wdata[0];

   // ************************************************************
   // edge detector
   // ************************************************************
   eip_edge_det u_edge_det (
      .clk_sys_i (clk_sys_i),
      .rst_b_i (rst_b_i),
      .ce_i (ce_i),
      .en_i (pin_function_sel_r),
      .pol_i (edge_polarity_sel_r),
      .pin_i (shared_port_pin_i),
      .edge_o (edge_w)
   );

   // ************************************************************
   // next values
   // ************************************************************
   wire logic pend_clr_w = wr_pend_w & ~wbit_w & irq_pending_flag_r;
   wire logic pend_set_w = ce_i & edge_w;
   wire logic func_nxt = wr_func_w ? wbit_w : pin_function_sel_r;
   wire logic pol_nxt = wr_pol_w ? wbit_w : edge_polarity_sel_r;
   wire logic en_nxt = wr_en_w ? wbit_w : irq_pin_enable_r;
   wire logic pend_nxt = pend_set_w | (irq_pending_flag_r & ~pend_clr_w);
   wire logic [eip_pkg::EVT_W-1:0] evt_set_w = {pend_set_w & irq_pending_flag_r, pend_set_w};
   wire logic [eip_pkg::EVT_W-1:0] evt_status_nxt =
      evt_set_w | (rd_stat_w ? {eip_pkg::EVT_W{1'h0}} : evt_status_r);
   wire logic [eip_pkg::EVT_W-1:0] evt_mask_nxt =
      wr_mask_w ? bus_req_i.wdata[eip_pkg::EVT_W-1:0] : evt_mask_r;
   wire logic irq_req_nxt = pend_nxt & en_nxt;
   wire logic evt_irq_nxt = |(evt_status_nxt & evt_mask_nxt);

   // ************************************************************
   // read data select
   // ************************************************************
   wire logic [7:0] rd_sel_w =
      hit_func_w ? {7'h00, pin_function_sel_r} :
      hit_pol_w ? {7'h00, edge_polarity_sel_r} :
      hit_en_w ? {7'h00, irq_pin_enable_r} :
      hit_pend_w ? {7'h00, irq_pending_flag_r} :
      hit_stat_w ? {6'h00, evt_status_r} :
      hit_mask_w ? {6'h00, evt_mask_r} :
      hit_port_w ? {7'h00, shared_port_pin_i} :
      8'h00;
   wire logic [7:0] rdata_nxt = rd_w ? rd_sel_w : eip_pkg::RST_RDATA;

   // ************************************************************
   // control registers
   // ************************************************************
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pin_function_sel_r <= eip_pkg::RST_PIN_FUNC_SEL;
         edge_polarity_sel_r <= eip_pkg::RST_EDGE_POL_SEL;
         irq_pin_enable_r <= eip_pkg::RST_IRQ_PIN_EN;
         evt_mask_r <= eip_pkg::RST_EVT;
      end else if (ce_i) begin
         pin_function_sel_r <= func_nxt;
         edge_polarity_sel_r <= pol_nxt;
         irq_pin_enable_r <= en_nxt;
         evt_mask_r <= evt_mask_nxt;
      end
   end

   // ************************************************************
   // flags and outputs
   // ************************************************************
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_pending_flag_r <= eip_pkg::RST_IRQ_PEND_FLAG;
         evt_status_r <= eip_pkg::RST_EVT;
         rdata_r <= eip_pkg::RST_RDATA;
         irq_req_r <= 1'h0;
         evt_irq_r <= 1'h0;
      end else if (ce_i) begin
         irq_pending_flag_r <= pend_nxt;
         evt_status_r <= evt_status_nxt;
         rdata_r <= rdata_nxt;
         irq_req_r <= irq_req_nxt;
         evt_irq_r <= evt_irq_nxt;
      end
   end

   assign rdata_o = rdata_r;
   assign pin_is_irq_o = pin_function_sel_r;
   assign irq_req_o = irq_req_r;
   assign evt_irq_o = evt_irq_r;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb_sys @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_b_i);

   sequence s_pend_write(logic v);
      wr_pend_w && (wbit_w == v) && !pend_set_w;
   endsequence

   sequence s_func_write;
      wr_func_w;
   endsequence

   property p_func_sel;
      s_func_write |=> pin_is_irq_o == $past(wbit_w);
   endproperty
   a_func_sel: assert property (p_func_sel) else $error("pin function not updated");

   property p_port_mode_quiet;
      ce_i && !pin_function_sel_r |=> !edge_w;
   endproperty
   a_port_mode_quiet: assert property (p_port_mode_quiet) else $error("edge in port mode");

   property p_en_blocks;
      wr_en_w && !wbit_w |=> !irq_req_o;
   endproperty
   a_en_blocks: assert property (p_en_blocks) else $error("request not blocked");

   property p_pend_set;
      pend_set_w |=> irq_pending_flag_r ##0 (irq_req_o == irq_pin_enable_r);
   endproperty
   a_pend_set: assert property (p_pend_set) else $error("pending not set by edge");

   property p_set_cause;
      ce_i && !irq_pending_flag_r ##1 irq_pending_flag_r |-> $past(edge_w);
   endproperty
   a_set_cause: assert property (p_set_cause) else $error("pending set without edge");

   property p_pend_clear;
      s_pend_write(1'h0) and irq_pending_flag_r |=> !irq_pending_flag_r && !irq_req_o;
   endproperty
   a_pend_clear: assert property (p_pend_clear) else $error("pending not cleared");

   property p_write_one;
      s_pend_write(1'h1) |=> irq_pending_flag_r == $past(irq_pending_flag_r);
   endproperty
   a_write_one: assert property (p_write_one) else $error("write of one changed flag");

   property p_set_wins;
      wr_pend_w && !wbit_w && pend_set_w |=> irq_pending_flag_r;
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("edge lost against clear");

   property p_req_level;
      irq_req_o == (irq_pending_flag_r && irq_pin_enable_r);
   endproperty
   a_req_level: assert property (p_req_level) else $error("request level wrong");

   property p_read_once;
      rd_w |=> ##1 (!$past(ce_i) || rdata_o == 8'h00 || $past(rd_w));
   endproperty
   a_read_once: assert property (p_read_once) else $error("read data held too long");

   property p_stat_clear;
      rd_stat_w && !pend_set_w |=> evt_status_r == 2'h0 ##0 !evt_irq_o;
   endproperty
   a_stat_clear: assert property (p_stat_clear) else $error("status not cleared by read");

   property p_freeze;
      !ce_i |=> $stable(irq_pending_flag_r) && $stable(rdata_o) && $stable(evt_status_r);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

   property p_evt_edge;
      pend_set_w |=> evt_status_r[eip_pkg::EVT_EDGE_BIT];
   endproperty
   a_evt_edge: assert property (p_evt_edge) else $error("edge bit not set");

   property p_evt_overrun;
      pend_set_w && irq_pending_flag_r |=> evt_status_r[eip_pkg::EVT_OVERRUN_BIT];
   endproperty
   a_evt_overrun: assert property (p_evt_overrun) else $error("overrun bit not set");

   property p_evt_irq_level;
      evt_irq_o == |(evt_status_r & evt_mask_r);
   endproperty
   a_evt_irq_level: assert property (p_evt_irq_level) else $error("event request level wrong");

   property p_en_passes;
      wr_en_w && wbit_w && irq_pending_flag_r |=> irq_req_o;
   endproperty
   a_en_passes: assert property (p_en_passes) else $error("request not passed");

   property p_rd_pend;
      rd_w && hit_pend_w |=> rdata_o == {7'h00, $past(irq_pending_flag_r)};
   endproperty
   a_rd_pend: assert property (p_rd_pend) else $error("pending read data wrong");

   sequence s_flag_fall;
      ce_i && irq_pending_flag_r ##1 !irq_pending_flag_r;
   endsequence

   property p_clear_cause;
      s_flag_fall |-> $past(pend_clr_w);
   endproperty
   a_clear_cause: assert property (p_clear_cause) else $error("pending fell without clear");

   property p_port_read;
      rd_w && hit_port_w |=> rdata_o == {7'h00, $past(shared_port_pin_i)};
   endproperty
   a_port_read: assert property (p_port_read) else $error("pin level read wrong");

endmodule : eip_edge_irq_pin_unit

// ---- eip_pin_drv.sv ----
// external device model driving the shared interrupt pin
// assumes the pin is sampled on the rising edge of clk_sys_i
`timescale 1ns/10ps
module eip_pin_drv (
   input wire logic clk_sys_i,
   output logic level_o
);
   // ************************************************************
   // pin level
   // ************************************************************
   initial begin
      level_o = 1'b1;
   end

   // change the level after an edge, then hold it for a number of cycles
   task automatic put(input logic v, input int hold);
      @(posedge clk_sys_i);
      level_o <= v;
      repeat (hold) @(posedge clk_sys_i);
   endtask : put
endmodule : eip_pin_drv

// ---- eip_pkg.sv ----
// constants, field positions and carrier types of the external edge interrupt pin unit
// assumes a byte-wide register port with 16-bit addresses on the processor side
package eip_pkg;

   // ************************************************************
   // register addresses
   // ************************************************************
   localparam logic [15:0] ADDR_PIN_FUNC_SEL = 16'hffc9;
   localparam logic [15:0] ADDR_EDGE_POL_CTL = 16'hfff2;
   localparam logic [15:0] ADDR_IRQ_EN_CTL = 16'hfff3;
   localparam logic [15:0] ADDR_IRQ_PEND_STS = 16'hfff6;
   localparam logic [15:0] ADDR_EVT_STATUS = 16'hfff8;
   localparam logic [15:0] ADDR_EVT_MASK = 16'hfff9;
   localparam logic [15:0] ADDR_PORT_LEVEL = 16'hfffa;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int PIN_FUNC_SEL_BIT = 0;
   localparam int EDGE_POL_SEL_BIT = 0;
   localparam int IRQ_PIN_EN_BIT = 0;
   localparam int IRQ_PEND_FLAG_BIT = 0;
   localparam int PORT_LEVEL_BIT = 0;
   localparam int EVT_EDGE_BIT = 0;
   localparam int EVT_OVERRUN_BIT = 1;
   localparam int EVT_W = 2;

   // ************************************************************
   // values after reset
   // ************************************************************
   localparam logic RST_PIN_FUNC_SEL = 1'h0;
   localparam logic RST_EDGE_POL_SEL = 1'h0;
   localparam logic RST_IRQ_PIN_EN = 1'h0;
   localparam logic RST_IRQ_PEND_FLAG = 1'h0;
   localparam logic [EVT_W-1:0] RST_EVT = 2'h0;
   localparam logic [7:0] RST_RDATA = 8'h00;

   // ************************************************************
   // carrier types
   // ************************************************************
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } eip_bus_req_s;

endpackage : eip_pkg

// ---- testbench.sv ----
// self-checking bench of the external edge interrupt pin unit
// assumes the device model drives the pin and the bench acts as processor
`timescale 1ns/10ps
module testbench;
   logic clk_sys_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic ce_i = 1'b1;
   eip_pkg::eip_bus_req_s req = '0;
   logic [7:0] rdata_o;
   logic pin;
   logic pin_is_irq_o;
   logic irq_req_o;
   logic evt_irq_o;
   int failures = 0;
   int checks = 0;

   always #20 clk_sys_i = ~clk_sys_i;

   eip_pin_drv drv (.clk_sys_i(clk_sys_i), .level_o(pin));

   eip_edge_irq_pin_unit DUT (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
      .bus_req_i(req), .rdata_o(rdata_o), .shared_port_pin_i(pin),
      .pin_is_irq_o(pin_is_irq_o), .irq_req_o(irq_req_o), .evt_irq_o(evt_irq_o));

   // ************************************************************
   // shared tasks
   // ************************************************************
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys_i);
      req.wr <= 1'b0;
   endtask : wr

   task automatic rd(input string name, input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk_sys_i);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys_i);
      req.rd <= 1'b0;
      #1;
      chk(name, rdata_o, exp);
   endtask : rd

   task automatic settle();
      @(posedge clk_sys_i);
      #1;
   endtask : settle

   task automatic summarize();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : summarize

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic sc_reset();
      rd("func_rst", eip_pkg::ADDR_PIN_FUNC_SEL, 8'h00);
      rd("pol_rst", eip_pkg::ADDR_EDGE_POL_CTL, 8'h00);
      rd("en_rst", eip_pkg::ADDR_IRQ_EN_CTL, 8'h00);
      rd("pend_rst", eip_pkg::ADDR_IRQ_PEND_STS, 8'h00);
      rd("evt_rst", eip_pkg::ADDR_EVT_STATUS, 8'h00);
      rd("mask_rst", eip_pkg::ADDR_EVT_MASK, 8'h00);
      rd("level", eip_pkg::ADDR_PORT_LEVEL, 8'h01);
      rd("unmapped", 16'h1234, 8'h00);
      chk("pin_is_irq_rst", {7'h00, pin_is_irq_o}, 8'h00);
   endtask : sc_reset

   task automatic sc_port_mode();
      drv.put(1'b0, 4);
      rd("pend_port", eip_pkg::ADDR_IRQ_PEND_STS, 8'h00);
      drv.put(1'b1, 4);
      wr(eip_pkg::ADDR_PIN_FUNC_SEL, 8'hff);
      rd("func_rb", eip_pkg::ADDR_PIN_FUNC_SEL, 8'h01);
      chk("pin_is_irq", {7'h00, pin_is_irq_o}, 8'h01);
   endtask : sc_port_mode

   task automatic sc_polarity();
      drv.put(1'b0, 4);
      rd("pend_fall", eip_pkg::ADDR_IRQ_PEND_STS, 8'h01);
      wr(eip_pkg::ADDR_IRQ_PEND_STS, 8'h00);
      rd("pend_clr", eip_pkg::ADDR_IRQ_PEND_STS, 8'h00);
      drv.put(1'b1, 4);
      rd("pend_rise_p0", eip_pkg::ADDR_IRQ_PEND_STS, 8'h00);
      wr(eip_pkg::ADDR_EDGE_POL_CTL, 8'h01);
      rd("pol_rb", eip_pkg::ADDR_EDGE_POL_CTL, 8'h01);
      drv.put(1'b0, 4);
      rd("pend_fall_p1", eip_pkg::ADDR_IRQ_PEND_STS, 8'h00);
      drv.put(1'b1, 4);
      rd("pend_rise", eip_pkg::ADDR_IRQ_PEND_STS, 8'h01);
   endtask : sc_polarity

   task automatic sc_write_one();
      wr(eip_pkg::ADDR_IRQ_PEND_STS, 8'hff);
      rd("pend_w1_set", eip_pkg::ADDR_IRQ_PEND_STS, 8'h01);
      wr(eip_pkg::ADDR_IRQ_PEND_STS, 8'h00);
      rd("pend_w0", eip_pkg::ADDR_IRQ_PEND_STS, 8'h00);
      wr(eip_pkg::ADDR_IRQ_PEND_STS, 8'h01);
      rd("pend_w1_clr", eip_pkg::ADDR_IRQ_PEND_STS, 8'h00);
   endtask : sc_write_one

   task automatic sc_enable();
      drv.put(1'b0, 2);
      drv.put(1'b1, 4);
      settle();
      chk("irq_dis", {7'h00, irq_req_o}, 8'h00);
      wr(eip_pkg::ADDR_IRQ_EN_CTL, 8'h01);
      settle();
      chk("irq_en", {7'h00, irq_req_o}, 8'h01);
      wr(eip_pkg::ADDR_IRQ_EN_CTL, 8'h00);
      settle();
      chk("irq_redis", {7'h00, irq_req_o}, 8'h00);
      wr(eip_pkg::ADDR_IRQ_EN_CTL, 8'h01);
      wr(eip_pkg::ADDR_IRQ_PEND_STS, 8'h00);
      settle();
      chk("irq_clr", {7'h00, irq_req_o}, 8'h00);
   endtask : sc_enable

   task automatic sc_events();
      rd("evt_old", eip_pkg::ADDR_EVT_STATUS, 8'h01);
      wr(eip_pkg::ADDR_EVT_MASK, 8'h03);
      settle();
      chk("evt_idle", {7'h00, evt_irq_o}, 8'h00);
      drv.put(1'b0, 2);
      drv.put(1'b1, 4);
      settle();
      chk("evt_irq", {7'h00, evt_irq_o}, 8'h01);
      chk("irq_edge", {7'h00, irq_req_o}, 8'h01);
      drv.put(1'b0, 2);
      drv.put(1'b1, 4);
      rd("evt_both", eip_pkg::ADDR_EVT_STATUS, 8'h03);
      settle();
      chk("evt_cleared", {7'h00, evt_irq_o}, 8'h00);
      rd("evt_empty", eip_pkg::ADDR_EVT_STATUS, 8'h00);
      wr(eip_pkg::ADDR_EVT_MASK, 8'h00);
      drv.put(1'b0, 2);
      drv.put(1'b1, 4);
      settle();
      chk("evt_masked", {7'h00, evt_irq_o}, 8'h00);
      rd("evt_ovr", eip_pkg::ADDR_EVT_STATUS, 8'h03);
   endtask : sc_events

   task automatic sc_freeze();
      @(posedge clk_sys_i);
      ce_i <= 1'b0;
      wr(eip_pkg::ADDR_IRQ_PEND_STS, 8'h00);
      wr(eip_pkg::ADDR_IRQ_EN_CTL, 8'h00);
      drv.put(1'b0, 2);
      drv.put(1'b1, 2);
      settle();
      chk("frz_irq", {7'h00, irq_req_o}, 8'h01);
      rd("frz_rd", eip_pkg::ADDR_IRQ_PEND_STS, 8'h00);
      @(posedge clk_sys_i);
      ce_i <= 1'b1;
      rd("frz_pend", eip_pkg::ADDR_IRQ_PEND_STS, 8'h01);
      rd("frz_en", eip_pkg::ADDR_IRQ_EN_CTL, 8'h01);
      rd("frz_evt", eip_pkg::ADDR_EVT_STATUS, 8'h00);
   endtask : sc_freeze

   task automatic sc_set_wins();
      drv.put(1'b0, 2);
      fork
         drv.put(1'b1, 3);
         begin
            @(posedge clk_sys_i);
            wr(eip_pkg::ADDR_IRQ_PEND_STS, 8'h00);
         end
      join
      rd("pend_set_wins", eip_pkg::ADDR_IRQ_PEND_STS, 8'h01);
      chk("irq_set_wins", {7'h00, irq_req_o}, 8'h01);
      rd("evt_set_wins", eip_pkg::ADDR_EVT_STATUS, 8'h03);
   endtask : sc_set_wins

   task automatic sc_rereset();
      @(posedge clk_sys_i);
      rst_b_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      sc_reset();
   endtask : sc_rereset

   // ************************************************************
   // main sequence and watchdog
   // ************************************************************
   initial begin
      repeat (2) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      sc_reset();
      sc_port_mode();
      sc_polarity();
      sc_write_one();
      sc_enable();
      sc_events();
      sc_freeze();
      sc_set_wins();
      sc_rereset();
      summarize();
   end

   initial begin
      repeat (5000) @(posedge clk_sys_i);
      failures++;
      summarize();
   end
endmodule : testbench
